// file: hw/tec_pkg.sv
// constants, types and register map of the 8-bit timer/event counter
// assumes one 125 MHz core clock and an APB master with 32-bit data
//
// Notes on behaviour
// - 8-bit up-counter, plus one per selected clock pulse or event edge.
// - passing FFH reloads from preload, raises interrupt, keeps counting.
// - write while stopped loads both the counter and the preload store.
// - write while running loads preload only; counter takes it at overflow.
// - reading count/preload address returns the live counter value, duty A in PWM mode.
// - mode field bits 7..6: 00 PWM, 01 event, 10 timer, 11 pulse width.
// - count enable bit one lets counter run, zero halts it.
// - in PWM mode the count enable position has no counting effect.
// - timer, pulse width and PWM use prescaled clock; event mode uses pin.
// - prescale select n picks prescaled clock divided by 2 to the n.
// - prescale select is ignored when the event pin clocks the counter.
// - event mode counts one per pin transition of the selected edge.
// - edge select used only in event and pulse width modes.
// - PWM control shares timer control address; duty A shares count address.
// - three duty registers A, B, C under one shared PWM control.
// - bit 5 of timer and PWM control is unimplemented, reads zero.
// - edge select zero counts rising edges, one counts falling edges.
// - pulse width: wait edge, count until pin returns, clear enable.
// - PWM enable cleared drives every PWM channel output low.
package tec_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] TEC_OFS_COUNT = 8'h00;
  localparam logic [7:0] TEC_OFS_CTRL = 8'h04;
  localparam logic [7:0] TEC_OFS_DUTY_B = 8'h08;
  localparam logic [7:0] TEC_OFS_DUTY_C = 8'h0C;

  // ----------------------------------------
  // register select codes
  // ----------------------------------------
  localparam logic [2:0] TEC_SEL_NONE = 3'h0;
  localparam logic [2:0] TEC_SEL_COUNT = 3'h1;
  localparam logic [2:0] TEC_SEL_CTRL = 3'h2;
  localparam logic [2:0] TEC_SEL_DUTY_B = 3'h3;
  localparam logic [2:0] TEC_SEL_DUTY_C = 3'h4;

  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int TEC_MODE_HI = 7;
  localparam int TEC_MODE_LO = 6;
  localparam int TEC_UNUSED_BIT = 5;
  localparam int TEC_ENABLE_BIT = 4;
  localparam int TEC_EDGE_BIT = 3;
  localparam int TEC_PSC_HI = 2;
  localparam int TEC_PSC_LO = 0;
  localparam int TEC_PWM_EN_BIT = 0;
  localparam logic [7:0] TEC_CTRL_WMASK = 8'hDF;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] TEC_RST_COUNT = 8'h00;
  localparam logic [7:0] TEC_RST_CTRL = 8'h00;
  localparam logic [7:0] TEC_RST_DUTY = 8'h00;
  localparam logic [6:0] TEC_RST_PSC = 7'h00;
  localparam logic [7:0] TEC_FULL_COUNT = 8'hFF;

  // ----------------------------------------
  // operating modes and pulse width states
  // ----------------------------------------
  typedef enum logic [1:0] {
    TEC_MODE_PWM = 2'b00,
    TEC_MODE_EVENT = 2'b01,
    TEC_MODE_TIMER = 2'b10,
    TEC_MODE_WIDTH = 2'b11
  } tec_mode_e;

  typedef enum logic [1:0] {
    TEC_PW_IDLE = 2'b00,
    TEC_PW_WAIT = 2'b01,
    TEC_PW_MEASURE = 2'b10
  } tec_pw_state_e;

  // ----------------------------------------
  // state of the counter core
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] preload;
    logic [7:0] ctrl;
    logic [7:0] duty_a;
    logic [7:0] duty_b;
    logic [7:0] duty_c;
    logic ev_prev;
    tec_pw_state_e pw_st;
    logic ovf;
    logic [2:0] pwm_out;
    logic [31:0] rdata;
  } tec_core_s;

  typedef struct packed {
    logic [6:0] div;
  } tec_psc_s;

endpackage : tec_pkg

// file: hw/tec_tick_if.sv
// prescaler request and tick between the counter core and its divider
// assumes both ends on core_clk
`timescale 1ns/1ps
interface tec_tick_if;
  logic prescaled_clock;
  logic [2:0] psc_sel;
  logic tick;

  modport divider (input prescaled_clock, input psc_sel, output tick);
  modport core (output prescaled_clock, output psc_sel, input tick);
endinterface : tec_tick_if

// file: hw/tec_prescaler.sv
// divider of the prescaled clock pulse by 2 to the power of psc_sel
// assumes prescaled_clock is a one-cycle enable pulse on core_clk
`timescale 1ns/1ps
module tec_prescaler (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // tick request
  tec_tick_if.divider tk
);
  import tec_pkg::*;

  tec_psc_s st_ff;
  tec_psc_s nxt_st;
  logic [6:0] low_mask;

  // ----------------------------------------
  // divide by 2 to the n
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    low_mask = 7'((8'h01 << tk.psc_sel) - 8'h01);
    if (tk.prescaled_clock) begin
      nxt_st.div = st_ff.div + 7'h01;
    end
  end

  // code 0 passes every pulse, code 7 every 128th
  assign tk.tick = tk.prescaled_clock &&
                   ((st_ff.div & low_mask) == low_mask);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff.div <= TEC_RST_PSC;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : tec_prescaler

// file: hw/tec_core.sv
// 8-bit timer/event counter with preload, pulse width and PWM modes
// assumes an APB master on core_clk and synchronous event pin input
`timescale 1ns/1ps
module tec_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // count sources
  input wire logic prescaled_clock,
  input wire logic external_event_pin,
  // events and waveforms
  output logic overflow_irq,
  output logic [2:0] pwm_channel_output
);
  import tec_pkg::*;

  tec_core_s st_ff;
  tec_core_s nxt_st;
  tec_tick_if tk ();

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    logic [2:0] s;
    s = TEC_SEL_NONE;
    case (addr)
      TEC_OFS_COUNT: s = TEC_SEL_COUNT;
      TEC_OFS_CTRL: s = TEC_SEL_CTRL;
      TEC_OFS_DUTY_B: s = TEC_SEL_DUTY_B;
      TEC_OFS_DUTY_C: s = TEC_SEL_DUTY_C;
      default: s = TEC_SEL_NONE;
    endcase
    return s;
  endfunction : reg_sel

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  assign tk.prescaled_clock = prescaled_clock;
  assign tk.psc_sel = st_ff.ctrl[TEC_PSC_HI:TEC_PSC_LO];

  tec_prescaler u_psc (
    .core_clk(core_clk),
    .rst(rst),
    .tk(tk)
  );

  // ----------------------------------------
  // decoded control
  // ----------------------------------------
  tec_mode_e mode;
  logic t0_on;
  logic edge_sel;
  logic pwm_en;
  logic rise;
  logic fall;
  logic start_edge;
  logic end_edge;
  logic running;
  logic inc;
  logic [2:0] sel;
  logic wr;
  logic setup;
  logic [7:0] wbyte;

  assign mode = tec_mode_e'(st_ff.ctrl[TEC_MODE_HI:TEC_MODE_LO]);
  assign t0_on = st_ff.ctrl[TEC_ENABLE_BIT];
  assign edge_sel = st_ff.ctrl[TEC_EDGE_BIT];
  assign pwm_en = st_ff.ctrl[TEC_PWM_EN_BIT];
  assign rise = external_event_pin && !st_ff.ev_prev;
  assign fall = !external_event_pin && st_ff.ev_prev;
  // zero starts on falling edge in width mode, counts rising in event
  assign start_edge = edge_sel ? rise : fall;
  assign end_edge = edge_sel ? fall : rise;
  assign sel = reg_sel(paddr);
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && pstrb[0];
  assign wbyte = pwdata[7:0];

  // enable bit is ignored in PWM mode
  assign running = (mode == TEC_MODE_PWM) ? pwm_en : t0_on;

  // ----------------------------------------
  // count source selection
  // ----------------------------------------
  always_comb begin
    case (mode)
      TEC_MODE_TIMER: inc = t0_on && tk.tick;
      TEC_MODE_EVENT: inc = t0_on && (edge_sel ? fall : rise);
      TEC_MODE_WIDTH: inc = (st_ff.pw_st == TEC_PW_MEASURE) && tk.tick;
      TEC_MODE_PWM: inc = pwm_en && tk.tick;
      default: inc = 1'b0;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ev_prev = external_event_pin;
    nxt_st.ovf = 1'b0;

    // pulse width sequencer
    case (st_ff.pw_st)
      TEC_PW_IDLE: begin
        if (mode == TEC_MODE_WIDTH && t0_on) begin
          nxt_st.pw_st = TEC_PW_WAIT;
        end
      end
      TEC_PW_WAIT: begin
        if (mode != TEC_MODE_WIDTH || !t0_on) begin
          nxt_st.pw_st = TEC_PW_IDLE;
        end else if (start_edge) begin
          nxt_st.pw_st = TEC_PW_MEASURE;
        end
      end
      TEC_PW_MEASURE: begin
        if (mode != TEC_MODE_WIDTH || !t0_on) begin
          nxt_st.pw_st = TEC_PW_IDLE;
        end else if (end_edge) begin
          nxt_st.pw_st = TEC_PW_IDLE;
          nxt_st.ctrl[TEC_ENABLE_BIT] = 1'b0;
        end
      end
      default: nxt_st.pw_st = TEC_PW_IDLE;
    endcase

    // counting and overflow
    if (inc) begin
      if (st_ff.count == TEC_FULL_COUNT) begin
        nxt_st.count = st_ff.preload;
        nxt_st.ovf = 1'b1;
      end else begin
        nxt_st.count = st_ff.count + 8'h01;
      end
    end

    // software writes, shared addresses follow the mode
    if (wr) begin
      case (sel)
        TEC_SEL_COUNT: begin
          if (mode == TEC_MODE_PWM) begin
            nxt_st.duty_a = wbyte;
          end else begin
            nxt_st.preload = wbyte;
            if (!running) begin
              nxt_st.count = wbyte;
            end else if (inc && st_ff.count == TEC_FULL_COUNT) begin
              nxt_st.count = wbyte;
            end
          end
        end
        TEC_SEL_CTRL: nxt_st.ctrl = wbyte & TEC_CTRL_WMASK;
        TEC_SEL_DUTY_B: nxt_st.duty_b = wbyte;
        TEC_SEL_DUTY_C: nxt_st.duty_c = wbyte;
        default: nxt_st.ctrl = nxt_st.ctrl;
      endcase
    end

    // read data captured in the setup cycle
    if (setup) begin
      nxt_st.rdata = 32'h0000_0000;
      case (sel)
        TEC_SEL_COUNT: begin
          nxt_st.rdata[7:0] = (mode == TEC_MODE_PWM) ? st_ff.duty_a :
                              st_ff.count;
        end
        TEC_SEL_CTRL: nxt_st.rdata[7:0] = st_ff.ctrl & TEC_CTRL_WMASK;
        TEC_SEL_DUTY_B: nxt_st.rdata[7:0] = st_ff.duty_b;
        TEC_SEL_DUTY_C: nxt_st.rdata[7:0] = st_ff.duty_c;
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end

    // simple compare waveform per channel
    if (mode == TEC_MODE_PWM && pwm_en) begin
      nxt_st.pwm_out[0] = st_ff.count < st_ff.duty_a;
      nxt_st.pwm_out[1] = st_ff.count < st_ff.duty_b;
      nxt_st.pwm_out[2] = st_ff.count < st_ff.duty_c;
    end else begin
      nxt_st.pwm_out = 3'h0;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff.count <= TEC_RST_COUNT;
      st_ff.preload <= TEC_RST_COUNT;
      st_ff.ctrl <= TEC_RST_CTRL;
      st_ff.duty_a <= TEC_RST_DUTY;
      st_ff.duty_b <= TEC_RST_DUTY;
      st_ff.duty_c <= TEC_RST_DUTY;
      st_ff.ev_prev <= 1'b0;
      st_ff.pw_st <= TEC_PW_IDLE;
      st_ff.ovf <= 1'b0;
      st_ff.pwm_out <= 3'h0;
      st_ff.rdata <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = st_ff.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && (sel == TEC_SEL_NONE);
  assign overflow_irq = st_ff.ovf;
  assign pwm_channel_output = st_ff.pwm_out;

endmodule : tec_core

// file: tb/tec_ev_src.sv
// pulse source model on the external event pin
// assumes core_clk domain; pin idles low between pulses
`timescale 1ns/1ps
module tec_ev_src (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pulse request, len cycles high
  input wire logic go,
  input wire logic [7:0] len,
  // pin side
  output logic pin,
  output logic busy
);
  logic [7:0] cnt;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin <= 1'b0;
      busy <= 1'b0;
      cnt <= 8'h00;
    end else if (go && !busy) begin
      pin <= 1'b1;
      busy <= 1'b1;
      cnt <= len;
    end else if (busy) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h01) begin
        pin <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule : tec_ev_src

// file: tb/tec_core_props.sv
// checker of the timer/event counter core ports
// assumes bind onto tec_core
`timescale 1ns/1ps
module tec_core_props
  import tec_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // count sources and outputs
  input wire logic prescaled_clock,
  input wire logic external_event_pin,
  input wire logic overflow_irq,
  input wire logic [2:0] pwm_channel_output
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic hit;
  assign hit = paddr == TEC_OFS_COUNT || paddr == TEC_OFS_CTRL ||
    paddr == TEC_OFS_DUTY_B || paddr == TEC_OFS_DUTY_C;
  sequence s_acc; psel && penable; endsequence
  sequence s_rd; s_acc ##0 !pwrite; endsequence
  sequence s_off; s_acc ##0 pwrite && pstrb[0] && paddr == TEC_OFS_CTRL
    && pwdata[7:6] == 2'b00 && !pwdata[0]; endsequence
  a_ready_high: assert property (s_acc |-> pready)
    else $error("ready low in access");
  a_err_unmapped: assert property (s_acc ##0 !hit |-> pslverr)
    else $error("no error on unmapped");
  a_err_mapped: assert property (s_acc ##0 hit |-> !pslverr)
    else $error("error on mapped");
  a_rd_upper: assert property (s_rd |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_rd_unmapped: assert property (s_rd ##0 !hit |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_bit5: assert property (s_rd ##0 paddr == TEC_OFS_CTRL |->
    !prdata[5]) else $error("control bit 5 set");
  a_pwm_off: assert property (s_off |-> ##2 pwm_channel_output == 3'h0)
    else $error("pwm output not low");
  a_irq_cause: assert property (overflow_irq |-> $past(prescaled_clock) ||
    $past(prescaled_clock, 2) ||
    $past(external_event_pin) != $past(external_event_pin, 2))
    else $error("overflow without count");
endmodule : tec_core_props

bind tec_core tec_core_props u_props (.core_clk(core_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .prescaled_clock(prescaled_clock),
  .external_event_pin(external_event_pin), .overflow_irq(overflow_irq),
  .pwm_channel_output(pwm_channel_output));

// file: tb/timer_event_counter_8bit_tb.sv
// self-checking bench of the 8-bit timer/event counter
// assumes tec_core, its bound checker and the pin source model
`timescale 1ns/1ps
module timer_event_counter_8bit_tb;
  import tec_pkg::*;
  // ----------------------------------------
  // bench
  // ----------------------------------------
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic tick = 0, go = 0, pready, pslverr, slv, pin, busy, irq;
  logic [7:0] paddr = 0, len = 0, cur, p2;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 0;
  logic [2:0] pwm;
  logic [15:0] ex;
  int n_mismatch = 0, tests_run = 0, n_irq = 0, i0, seed = 32'h83f7;
  tec_core DUT (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prescaled_clock(tick), .external_event_pin(pin),
    .overflow_irq(irq), .pwm_channel_output(pwm));
  tec_ev_src u_src (.core_clk(core_clk), .rst(rst), .go(go), .len(len),
    .pin(pin), .busy(busy));
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (irq === 1'b1) n_irq++;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task lim(input int i, input int m);
    if (i >= m) begin
      n_mismatch++;
      complete_run();
    end
  endtask : lim
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int i;
    i = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 64);
    lim(i, 64);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'hF);
    chk(rd, e);
  endtask : rdc
  task pulses(input int k);
    repeat (k) begin
      @(posedge core_clk);
      tick <= 1'b1;
    end
    @(posedge core_clk);
    tick <= 1'b0;
  endtask : pulses
  task pin_go(input logic [7:0] l);
    @(posedge core_clk);
    len <= l;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
  endtask : pin_go
  task pin_end;
    int i;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (busy !== 1'b0 && i < 300);
    lim(i, 300);
  endtask : pin_end
  function automatic logic [15:0] run_exp(input logic [7:0] c, p,
    input int k);
    logic [7:0] o;
    o = 8'h00;
    repeat (k) begin
      if (c == 8'hFF) begin
        c = p;
        o++;
      end else c++;
    end
    return {o, c};
  endfunction : run_exp
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a += 4) rdc(8'(a), 32'h0);
    apb(1'b0, 8'h10, 32'h0, 4'hF);
    chk({31'h0, slv}, 32'h1);
    wr(TEC_OFS_CTRL, 32'hFF);
    rdc(TEC_OFS_CTRL, 32'hDF);
    wr(TEC_OFS_CTRL, 32'h80);
    wr(TEC_OFS_COUNT, 32'h5A);
    apb(1'b1, TEC_OFS_COUNT, 32'hA5, 4'hE);
    rdc(TEC_OFS_COUNT, 32'h5A);
    for (int n = 0; n < 8; n++) begin
      cur = 8'hFC | 8'($random(seed) & 3);
      wr(TEC_OFS_CTRL, 32'h80 | n);
      wr(TEC_OFS_COUNT, {24'h0, cur});
      rdc(TEC_OFS_COUNT, {24'h0, cur});
      wr(TEC_OFS_CTRL, 32'h90 | n | ((n & 1) << 3));
      i0 = n_irq;
      pulses(4 << n);
      ex = run_exp(cur, cur, 4);
      rdc(TEC_OFS_COUNT, {24'h0, ex[7:0]});
      chk(32'(n_irq - i0), {24'h0, ex[15:8]});
    end
    p2 = 8'($random(seed));
    wr(TEC_OFS_COUNT, {24'h0, p2});
    rdc(TEC_OFS_COUNT, {24'h0, ex[7:0]});
    ex = run_exp(ex[7:0], p2, 16);
    pulses(16 << 7);
    rdc(TEC_OFS_COUNT, {24'h0, ex[7:0]});
    wr(TEC_OFS_CTRL, 32'h87);
    pulses(300);
    rdc(TEC_OFS_COUNT, {24'h0, ex[7:0]});
    tick <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      wr(TEC_OFS_CTRL, 32'h40 | (e << 3) | ($random(seed) & 7));
      wr(TEC_OFS_COUNT, 32'h0);
      wr(TEC_OFS_CTRL, 32'h50 | (e << 3) | ($random(seed) & 7));
      pin_go(8'd40);
      rdc(TEC_OFS_COUNT, (e == 0) ? 32'h1 : 32'h0);
      pin_end();
      rdc(TEC_OFS_COUNT, 32'h1);
    end
    wr(TEC_OFS_CTRL, 32'hC8);
    wr(TEC_OFS_COUNT, 32'h0);
    wr(TEC_OFS_CTRL, 32'hD8);
    pin_go(8'd30);
    pin_end();
    apb(1'b0, TEC_OFS_COUNT, 32'h0, 4'hF);
    chk({31'h0, rd >= 26 && rd <= 31}, 32'h1);
    cur = rd[7:0];
    rdc(TEC_OFS_CTRL, 32'hC8);
    pin_go(8'd30);
    pin_end();
    rdc(TEC_OFS_COUNT, {24'h0, cur});
    tick <= 1'b0;
    wr(TEC_OFS_CTRL, 32'h80);
    wr(TEC_OFS_COUNT, 32'h10);
    wr(TEC_OFS_CTRL, 32'h1D);
    rdc(TEC_OFS_CTRL, 32'h1D);
    wr(TEC_OFS_COUNT, 32'h20);
    wr(TEC_OFS_DUTY_B, 32'h10);
    wr(TEC_OFS_DUTY_C, 32'h11);
    rdc(TEC_OFS_COUNT, 32'h20);
    rdc(TEC_OFS_DUTY_C, 32'h11);
    rdc(TEC_OFS_DUTY_B, 32'h10);
    chk({29'h0, pwm}, 32'h5);
    wr(TEC_OFS_CTRL, 32'h1C);
    repeat (2) @(posedge core_clk);
    chk({29'h0, pwm}, 32'h0);
    wr(TEC_OFS_CTRL, 32'h80);
    rdc(TEC_OFS_COUNT, 32'h10);
    complete_run();
  end
endmodule : timer_event_counter_8bit_tb
